// ===== pic_defs.svh
// Purpose: constants of the platform interrupt controller
// Assumes: byte addresses on a 32-bit classic Wishbone bus
// Notes:   definitions only
`ifndef PIC_DEFS_SVH
`define PIC_DEFS_SVH

`define PIC_NSRC          44
`define PIC_IDW           6
`define PIC_PRIW          4

`define PIC_SOFT_ADR      32'h0200_0000
`define PIC_TCMP_LO_ADR   32'h0200_4000
`define PIC_TCMP_HI_ADR   32'h0200_4004
`define PIC_TCNT_LO_ADR   32'h0200_BFF8
`define PIC_TCNT_HI_ADR   32'h0200_BFFC
`define PIC_PRIO_BASE     32'h0C00_0000
`define PIC_PEND_LO_ADR   32'h0C00_1000
`define PIC_PEND_HI_ADR   32'h0C00_1004
`define PIC_EN_LO_ADR     32'h0C00_2000
`define PIC_EN_HI_ADR     32'h0C00_2004
`define PIC_FLOOR_ADR     32'h0C20_0000
`define PIC_CLAIM_ADR     32'h0C20_0004
`define PIC_EVT_STAT_ADR  32'h0C30_0000
`define PIC_EVT_CLR_ADR   32'h0C30_0004
`define PIC_EVT_EN_ADR    32'h0C30_0008
`define PIC_CORE_MIE_ADR  32'h0C30_000C
`define PIC_CORE_GLB_ADR  32'h0C30_0010

`define PIC_MSIE_BIT      3
`define PIC_MTIE_BIT      7
`define PIC_MEIE_BIT      11
`define PIC_LOCAL_BIT     16
`define PIC_MIE_MASK      32'h000F_0888

`define PIC_CAUSE_SW      5'h03
`define PIC_CAUSE_TMR     5'h07
`define PIC_CAUSE_EXT     5'h0B
`define PIC_CAUSE_LOCAL   5'h10

`define PIC_EV_EXT        0
`define PIC_EV_TMR        1
`define PIC_EV_EMPTY      2
`define PIC_EV_BADCPL     3
`define PIC_NEV           4

`define PIC_TCMP_RST      64'hFFFF_FFFF_FFFF_FFFF
`define PIC_TCNT_RST      64'h0000_0000_0000_0000
`define PIC_UNMAPPED_DAT  32'h0000_0000

`endif

// ===== pic_pkg.sv
// Purpose: types of the platform interrupt controller
// Assumes: pic_defs.svh holds every number
// Notes:   one packed struct carries all state
`include "pic_defs.svh"

package pic_pkg;

  typedef struct packed {
    logic                                    ack;
    logic [31:0]                             dat;
    logic                                    soft_pend;
    logic [63:0]                             tcnt;
    logic [63:0]                             tcmp;
    logic                                    tmr_pend;
    logic [`PIC_NSRC:0][`PIC_PRIW-1:0]       prio;
    logic [`PIC_NSRC:0]                      pend;
    logic [`PIC_NSRC:0]                      en;
    logic [`PIC_NSRC:0]                      inflight;
    logic [`PIC_PRIW-1:0]                    floor;
    logic [`PIC_IDW-1:0]                     claim_id;
    logic                                    ext_req;
    logic [`PIC_NEV-1:0]                     evt_st;
    logic [`PIC_NEV-1:0]                     evt_en;
    logic                                    evt_irq;
    logic [31:0]                             core_mie;
    logic                                    glob_en;
    logic                                    core_irq;
    logic [4:0]                              core_cause;
  } pic_state_t;

endpackage

// ===== pic_top.sv
// Purpose: platform interrupt controller with machine timer and soft interrupt
// Assumes: sources and local lines come from logic on clk_i
// Notes:   classic Wishbone slave, one wait state, unmapped reads give zero
// Function
// - sixteen levels, 44 external channels, local lines
// - four local lines, fixed priority, direct path
// - external sources have programmable priority, one threshold
// - source identifiers fixed from 1 to 44
// - local3..local0, external, software, timer order
// - nothing reaches core_irq_o without global enable; evt_irq_o is not gated by it
// - per-type enable bits gate each interrupt
// - soft trigger bit 0 sets or clears
// - timer compare split low and high words
// - timer count split low and high words
// - per-source 4-bit priority, zero disables
// - hardware sets pending bit at identifier
// - software-writable enable bit per source
// - only priority above threshold signals core
// - claim read returns best id, clears pending
// - claim read returns zero when none qualifies
// - written id completes, source may signal again
`timescale 1ns/1ps
`include "pic_defs.svh"

module pic_top (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // wishbone slave
  input  wire logic                 cyc_i,
  input  wire logic                 stb_i,
  input  wire logic                 we_i,
  input  wire logic [31:0]          adr_i,
  input  wire logic [3:0]           sel_i,
  input  wire logic [31:0]          dat_i,
  output logic                      ack_o,
  output logic [31:0]               dat_o,
  // interrupt sources
  input  wire logic [`PIC_NSRC:1]   src_i,
  input  wire logic [3:0]           local_i,
  // core side
  output logic                      core_irq_o,
  output logic [4:0]                core_cause_o,
  output logic                      evt_irq_o
);

  pic_pkg::pic_state_t r;
  pic_pkg::pic_state_t n;
  logic [`PIC_IDW-1:0] best_id;
  logic                req;
  logic                commit;
  logic [`PIC_IDW-1:0] prio_id;
  logic [`PIC_IDW-1:0] cpl_id;
  logic [`PIC_NEV-1:0] ev;
  logic [`PIC_NEV-1:0] clr;
  logic [3:0]          loc;

  // byte-lane merge for full-word registers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction

  // priority slot decode: returns the source id, zero when no slot is hit
  function automatic logic [`PIC_IDW-1:0] prio_slot(input logic [31:0] adr);
    logic [`PIC_IDW-1:0] id;
    id = '0;
    for (int i = 1; i <= `PIC_NSRC; i++) begin
      if (adr == `PIC_PRIO_BASE + 32'(4 * i)) begin
        id = `PIC_IDW'(i);
      end
    end
    return id;
  endfunction

  // strict compare keeps the lowest id on a tie and excludes priority zero
  function automatic logic [`PIC_IDW-1:0] pick(input logic [`PIC_NSRC:0] pend,
                                                input logic [`PIC_NSRC:0] en,
                                                input logic [`PIC_NSRC:0][`PIC_PRIW-1:0] prio,
                                                input logic [`PIC_PRIW-1:0] floor);
    logic [`PIC_IDW-1:0]  id;
    logic [`PIC_PRIW-1:0] top;
    id  = '0;
    top = floor;
    for (int i = 1; i <= `PIC_NSRC; i++) begin
      if (pend[i] && en[i] && prio[i] > top) begin
        id  = `PIC_IDW'(i);
        top = prio[i];
      end
    end
    return id;
  endfunction

  always_comb begin
    n       = r;
    req     = cyc_i & stb_i;
    commit  = req & r.ack;
    prio_id = prio_slot(adr_i);
    cpl_id  = dat_i[`PIC_IDW-1:0];
    best_id = pick(r.pend, r.en, r.prio, r.floor);
    ev      = '0;
    clr     = '0;
    loc     = local_i & r.core_mie[`PIC_LOCAL_BIT +: 4];

    // bus handshake: ack one cycle after the request, then drop
    n.ack = req & ~r.ack;
    n.dat = `PIC_UNMAPPED_DAT;
    if (req && !r.ack && !we_i) begin
      if (prio_id != '0) begin
        n.dat = {28'h0, r.prio[prio_id]};
      end else begin
        case (adr_i)
          `PIC_SOFT_ADR:     n.dat = {31'h0, r.soft_pend};
          `PIC_TCMP_LO_ADR:  n.dat = r.tcmp[31:0];
          `PIC_TCMP_HI_ADR:  n.dat = r.tcmp[63:32];
          `PIC_TCNT_LO_ADR:  n.dat = r.tcnt[31:0];
          `PIC_TCNT_HI_ADR:  n.dat = r.tcnt[63:32];
          `PIC_PEND_LO_ADR:  n.dat = r.pend[31:0];
          `PIC_PEND_HI_ADR:  n.dat = {19'h0, r.pend[`PIC_NSRC:32]};
          `PIC_EN_LO_ADR:    n.dat = r.en[31:0];
          `PIC_EN_HI_ADR:    n.dat = {19'h0, r.en[`PIC_NSRC:32]};
          `PIC_FLOOR_ADR:    n.dat = {28'h0, r.floor};
          `PIC_CLAIM_ADR:    n.dat = {26'h0, best_id};
          `PIC_EVT_STAT_ADR: n.dat = {28'h0, r.evt_st};
          `PIC_EVT_EN_ADR:   n.dat = {28'h0, r.evt_en};
          `PIC_CORE_MIE_ADR: n.dat = r.core_mie;
          `PIC_CORE_GLB_ADR: n.dat = {31'h0, r.glob_en};
          default:           n.dat = `PIC_UNMAPPED_DAT;
        endcase
      end
    end
    // claim id is frozen with the read data so the clear hits the returned source
    if (req && !r.ack && !we_i && adr_i == `PIC_CLAIM_ADR) begin
      n.claim_id = best_id;
    end

    // timer runs every cycle; a written half replaces the incremented value
    n.tcnt = r.tcnt + 64'h1;

    // pending bits latch a high source level unless the source is claimed, and stay set until claimed
    for (int i = 1; i <= `PIC_NSRC; i++) begin
      n.pend[i] = r.pend[i] | (src_i[i] & ~r.inflight[i]);
    end

    // writes and read side effects take place at the edge that samples ack
    if (commit && we_i) begin
      if (prio_id != '0 && sel_i[0]) begin
        n.prio[prio_id] = dat_i[`PIC_PRIW-1:0];
      end
      case (adr_i)
        `PIC_SOFT_ADR: begin
          if (sel_i[0]) begin
            n.soft_pend = dat_i[0];
          end
        end
        `PIC_TCMP_LO_ADR:  n.tcmp[31:0]  = merge(r.tcmp[31:0], dat_i, sel_i);
        `PIC_TCMP_HI_ADR:  n.tcmp[63:32] = merge(r.tcmp[63:32], dat_i, sel_i);
        `PIC_TCNT_LO_ADR:  n.tcnt[31:0]  = merge(r.tcnt[31:0], dat_i, sel_i);
        `PIC_TCNT_HI_ADR:  n.tcnt[63:32] = merge(r.tcnt[63:32], dat_i, sel_i);
        `PIC_EN_LO_ADR:    n.en[31:0]    = merge(r.en[31:0], dat_i, sel_i) & 32'hFFFF_FFFE;
        `PIC_EN_HI_ADR:    n.en[`PIC_NSRC:32] = 13'(merge({19'h0, r.en[`PIC_NSRC:32]}, dat_i, sel_i));
        `PIC_FLOOR_ADR: begin
          if (sel_i[0]) begin
            n.floor = dat_i[`PIC_PRIW-1:0];
          end
        end
        `PIC_CLAIM_ADR: begin
          if (cpl_id != '0 && cpl_id <= `PIC_IDW'(`PIC_NSRC) && r.inflight[cpl_id]) begin
            n.inflight[cpl_id] = 1'b0;
          end else begin
            ev[`PIC_EV_BADCPL] = 1'b1;
          end
        end
        `PIC_EVT_CLR_ADR:  clr      = dat_i[`PIC_NEV-1:0];
        `PIC_EVT_EN_ADR:   n.evt_en = dat_i[`PIC_NEV-1:0];
        `PIC_CORE_MIE_ADR: n.core_mie = merge(r.core_mie, dat_i, sel_i) & `PIC_MIE_MASK;
        `PIC_CORE_GLB_ADR: begin
          if (sel_i[0]) begin
            n.glob_en = dat_i[0];
          end
        end
        default: ;
      endcase
    end
    if (commit && !we_i && adr_i == `PIC_CLAIM_ADR) begin
      if (r.claim_id != '0) begin
        n.pend[r.claim_id]     = 1'b0;
        n.inflight[r.claim_id] = 1'b1;
      end else begin
        ev[`PIC_EV_EMPTY] = 1'b1;
      end
    end
    n.pend[0] = 1'b0;

    n.tmr_pend = (r.tcnt >= r.tcmp);
    n.ext_req  = (best_id != '0);
    ev[`PIC_EV_EXT] = n.ext_req & ~r.ext_req;
    ev[`PIC_EV_TMR] = n.tmr_pend & ~r.tmr_pend;
    // a new event wins over a clear in the same cycle
    n.evt_st  = (r.evt_st & ~clr) | ev;
    n.evt_irq = |(n.evt_st & n.evt_en);

    // lowest first so that each higher candidate overwrites
    n.core_irq   = 1'b0;
    n.core_cause = 5'h00;
    if (r.glob_en) begin
      if (r.tmr_pend && r.core_mie[`PIC_MTIE_BIT]) begin
        n.core_irq   = 1'b1;
        n.core_cause = `PIC_CAUSE_TMR;
      end
      if (r.soft_pend && r.core_mie[`PIC_MSIE_BIT]) begin
        n.core_irq   = 1'b1;
        n.core_cause = `PIC_CAUSE_SW;
      end
      if (r.ext_req && r.core_mie[`PIC_MEIE_BIT]) begin
        n.core_irq   = 1'b1;
        n.core_cause = `PIC_CAUSE_EXT;
      end
      for (int k = 0; k < 4; k++) begin
        if (loc[k]) begin
          n.core_irq   = 1'b1;
          n.core_cause = `PIC_CAUSE_LOCAL + 5'(k);
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r      <= '0;
      r.tcmp <= `PIC_TCMP_RST;
      r.tcnt <= `PIC_TCNT_RST;
    end else begin
      r <= n;
    end
  end

  assign ack_o        = r.ack;
  assign dat_o        = r.dat;
  assign core_irq_o   = r.core_irq;
  assign core_cause_o = r.core_cause;
  assign evt_irq_o    = r.evt_irq;

  // checks
  a_global_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    !r.glob_en |=> !core_irq_o)
    else $error("interrupt reached core without global enable");

  a_local_top: assert property (@(posedge clk_i) disable iff (rst_i)
    (r.glob_en && local_i[3] && r.core_mie[`PIC_LOCAL_BIT + 3]) |=> (core_irq_o && core_cause_o == 5'h13))
    else $error("local line 3 did not win");

  a_type_enable: assert property (@(posedge clk_i) disable iff (rst_i)
    (r.core_mie == 32'h0) |=> !core_irq_o)
    else $error("interrupt passed with all type enables clear");

  a_soft_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && we_i && ack_o && sel_i[0] && adr_i == `PIC_SOFT_ADR) |=> (r.soft_pend == $past(dat_i[0])))
    else $error("soft trigger bit not stored");

  a_timer_count: assert property (@(posedge clk_i) disable iff (rst_i)
    !(cyc_i && stb_i && we_i) |=> (r.tcnt == $past(r.tcnt) + 64'h1))
    else $error("timer count did not advance");

  a_timer_pend: assert property (@(posedge clk_i) disable iff (rst_i)
    (r.tcnt >= r.tcmp) |=> r.tmr_pend)
    else $error("timer pending missing at compare");

  a_claim_data: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !we_i && !ack_o && adr_i == `PIC_CLAIM_ADR) |=> (ack_o && dat_o == {26'h0, $past(best_id)}))
    else $error("claim read returned wrong id");

  a_claim_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !we_i && ack_o && adr_i == `PIC_CLAIM_ADR && r.claim_id != '0)
      |=> (!r.pend[$past(r.claim_id)] && r.inflight[$past(r.claim_id)]))
    else $error("claimed source still pending");

  a_floor_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    (best_id != '0) |-> (r.prio[best_id] > r.floor && r.en[best_id]))
    else $error("source at or below threshold selected");

  a_claimed_block: assert property (@(posedge clk_i) disable iff (rst_i)
    (best_id != '0) |-> !r.inflight[best_id])
    else $error("claimed source forwarded again");

  a_complete_free: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && we_i && ack_o && adr_i == `PIC_CLAIM_ADR && dat_i[5:0] != 6'h00 && dat_i[5:0] <= 6'h2C)
      |=> !r.inflight[$past(dat_i[5:0])])
    else $error("completed source not released");

  a_ack_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !ack_o) |=> ack_o)
    else $error("request not answered after one wait state");

  a_pend_set: assert property (@(posedge clk_i) disable iff (rst_i)
    (src_i[3] && !r.inflight[3] && !(cyc_i && stb_i && !we_i && ack_o && adr_i == `PIC_CLAIM_ADR))
      |=> r.pend[3])
    else $error("triggered source not pending");

  a_enable_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && we_i && ack_o && sel_i == 4'hF && adr_i == `PIC_EN_LO_ADR)
      |=> (r.en[31:1] == $past(dat_i[31:1])))
    else $error("enable bits not stored");

  a_prio_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && we_i && ack_o && sel_i[0] && adr_i == `PIC_PRIO_BASE + 32'h0000_000C)
      |=> (r.prio[3] == $past(dat_i[3:0])))
    else $error("source priority not stored");

  a_floor_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && we_i && ack_o && sel_i[0] && adr_i == `PIC_FLOOR_ADR)
      |=> (r.floor == $past(dat_i[3:0])))
    else $error("threshold not stored");

  a_cmp_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && we_i && ack_o && sel_i == 4'hF && adr_i == `PIC_TCMP_LO_ADR)
      |=> (r.tcmp[31:0] == $past(dat_i)))
    else $error("timer compare low word not stored");

  a_count_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && we_i && ack_o && sel_i == 4'hF && adr_i == `PIC_TCNT_HI_ADR)
      |=> (r.tcnt[63:32] == $past(dat_i)))
    else $error("timer count high word not stored");

  a_ext_over_soft: assert property (@(posedge clk_i) disable iff (rst_i)
    (r.glob_en && r.ext_req && r.core_mie[`PIC_MEIE_BIT] && (local_i & r.core_mie[`PIC_LOCAL_BIT +: 4]) == 4'h0)
      |=> (core_irq_o && core_cause_o == `PIC_CAUSE_EXT))
    else $error("external request lost to a lower type");

  a_soft_over_timer: assert property (@(posedge clk_i) disable iff (rst_i)
    (r.glob_en && r.soft_pend && r.core_mie[`PIC_MSIE_BIT] && !(r.ext_req && r.core_mie[`PIC_MEIE_BIT])
      && (local_i & r.core_mie[`PIC_LOCAL_BIT +: 4]) == 4'h0)
      |=> (core_irq_o && core_cause_o == `PIC_CAUSE_SW))
    else $error("software request lost to timer");

  a_empty_event: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !we_i && ack_o && adr_i == `PIC_CLAIM_ADR && dat_o == 32'h0000_0000)
      |=> r.evt_st[`PIC_EV_EMPTY])
    else $error("empty claim not flagged");

  a_event_level: assert property (@(posedge clk_i) disable iff (rst_i)
    evt_irq_o == |(r.evt_st & r.evt_en))
    else $error("event interrupt does not follow status and enable");

endmodule // pic_top

// ===== pic_src_model.sv
// Purpose: peripheral side model driving external sources and local lines
// Assumes: requests stay level until the handler silences the peripheral
// Notes:   lines are registered on clk_i, so each change shows one edge later
`timescale 1ns/1ps
`include "pic_defs.svh"

module pic_src_model (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // commands from the bench
  input  wire logic [`PIC_NSRC:1]   src_set_i,
  input  wire logic [3:0]           local_set_i,
  // lines into the controller
  output logic      [`PIC_NSRC:1]   src_o,
  output logic      [3:0]           local_o
);
  // lines copy the bench commands one edge later; a line left high re-pends its source after completion
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_o   <= '0;
      local_o <= '0;
    end else begin
      src_o   <= src_set_i;
      local_o <= local_set_i;
    end
  end
endmodule // pic_src_model

// ===== platform_interrupt_controller_test.sv
// Purpose: self-checking bench for the platform interrupt controller
// Assumes: outputs settle within four edges
// Notes:   sources come from pic_src_model, registers via classic Wishbone
`timescale 1ns/1ps
`include "pic_defs.svh"

module platform_interrupt_controller_test;
  logic               clk_i, rst_i, cyc_i, stb_i, we_i;
  logic [31:0]        adr_i, dat_i, dat_o, rd, t0;
  logic [3:0]         sel_i, local_i, local_set;
  logic               ack_o, core_irq_o, evt_irq_o;
  logic [4:0]         core_cause_o;
  logic [`PIC_NSRC:1] src_i, src_set;
  int                 n_mismatch, comparisons, cycles;

  pic_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o), .dat_o(dat_o), .src_i(src_i), .local_i(local_i),
    .core_irq_o(core_irq_o), .core_cause_o(core_cause_o), .evt_irq_o(evt_irq_o));
  pic_src_model srcs (.clk_i(clk_i), .rst_i(rst_i), .src_set_i(src_set), .local_set_i(local_set),
    .src_o(src_i), .local_o(local_i));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 5000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("counts: %0d mismatches, %0d comparisons", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic fail(input string m);
    n_mismatch++;
    $display("mismatch at %0t: %s", $time, m);
  endtask

  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) fail($sformatf("data %h expected %h", g, e));
  endtask

  task automatic chk_irq(input logic irq, input logic [4:0] cause);
    comparisons++;
    if (core_irq_o !== irq || core_cause_o !== cause)
      fail($sformatf("core irq %b cause %h expected %b %h", core_irq_o, core_cause_o, irq, cause));
  endtask

  task automatic chk_bit(input logic g, input logic e);
    comparisons++;
    if (g !== e) fail($sformatf("flag %b expected %b", g, e));
  endtask

  // one classic cycle; ack and read data taken at the rising edge, request released there
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk32(rd, e);
  endtask

  task automatic settle();
    repeat (4) @(posedge clk_i);
  endtask

  initial begin
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i, src_set, local_set} = '0;
    {n_mismatch, comparisons, cycles} = '0;
    rst_i = 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(`PIC_TCMP_LO_ADR, 32'hFFFF_FFFF);
    rdc(`PIC_TCMP_HI_ADR, 32'hFFFF_FFFF);
    rdc(`PIC_TCNT_HI_ADR, 32'h0000_0000);
    bus(1'b0, `PIC_TCNT_LO_ADR, 32'h0000_0000);
    t0 = rd;
    bus(1'b0, `PIC_TCNT_LO_ADR, 32'h0000_0000);
    chk_bit(rd > t0, 1'b1);
    rdc(32'h0C30_0020, 32'h0000_0000);
    $display("test reset and timer words done");

    wr(`PIC_CORE_MIE_ADR, `PIC_MIE_MASK);
    wr(`PIC_SOFT_ADR, 32'h0000_0001);
    settle();
    chk_irq(1'b0, 5'h00);
    wr(`PIC_CORE_GLB_ADR, 32'h0000_0001);
    settle();
    chk_irq(1'b1, `PIC_CAUSE_SW);
    wr(`PIC_SOFT_ADR, 32'h0000_0000);
    settle();
    chk_irq(1'b0, 5'h00);
    wr(`PIC_CORE_MIE_ADR, 32'h0000_0000);
    wr(`PIC_SOFT_ADR, 32'h0000_0001);
    settle();
    chk_irq(1'b0, 5'h00);
    wr(`PIC_CORE_MIE_ADR, `PIC_MIE_MASK);
    wr(`PIC_TCMP_HI_ADR, 32'h0000_0000);
    wr(`PIC_TCMP_LO_ADR, 32'h0000_0000);
    settle();
    chk_irq(1'b1, `PIC_CAUSE_SW);
    wr(`PIC_SOFT_ADR, 32'h0000_0000);
    settle();
    chk_irq(1'b1, `PIC_CAUSE_TMR);
    wr(`PIC_TCMP_LO_ADR, 32'hFFFF_FFFF);
    settle();
    chk_irq(1'b0, 5'h00);
    wr(`PIC_SOFT_ADR, 32'h0000_0001);
    $display("test global, soft and timer done");

    for (int k = 0; k < 4; k++) begin
      @(posedge clk_i);
      local_set[k] <= 1'b1;
      settle();
      chk_irq(1'b1, `PIC_CAUSE_LOCAL + 5'(k));
    end
    wr(`PIC_CORE_MIE_ADR, 32'h0007_0888);
    settle();
    chk_irq(1'b1, 5'h12);
    wr(`PIC_CORE_MIE_ADR, `PIC_MIE_MASK);
    local_set <= 4'h0;
    settle();
    chk_irq(1'b1, `PIC_CAUSE_SW);
    $display("test local lines done");

    wr(`PIC_PRIO_BASE + 32'd12, 32'h0000_0003);
    wr(`PIC_PRIO_BASE + 32'd20, 32'h0000_0003);
    wr(`PIC_PRIO_BASE + 32'd132, 32'h0000_0001);
    wr(`PIC_EN_LO_ADR, 32'h0000_00A8);
    wr(`PIC_EN_HI_ADR, 32'h0000_0002);
    wr(`PIC_FLOOR_ADR, 32'h0000_0003);
    src_set <= 44'h1_0000_0054; // sources 3, 5, 7 and 33
    settle();
    rdc(`PIC_PEND_LO_ADR, 32'h0000_00A8);
    rdc(`PIC_PEND_HI_ADR, 32'h0000_0002);
    chk_irq(1'b1, `PIC_CAUSE_SW);
    wr(`PIC_FLOOR_ADR, 32'h0000_0002);
    settle();
    chk_irq(1'b1, `PIC_CAUSE_EXT);
    rdc(`PIC_CLAIM_ADR, 32'h0000_0003);
    rdc(`PIC_CLAIM_ADR, 32'h0000_0005);
    rdc(`PIC_PEND_LO_ADR, 32'h0000_0080);
    wr(`PIC_EVT_EN_ADR, 32'h0000_0004);
    rdc(`PIC_CLAIM_ADR, 32'h0000_0000);
    settle();
    chk_bit(evt_irq_o, 1'b1);
    wr(`PIC_EVT_CLR_ADR, 32'h0000_0004);
    settle();
    chk_bit(evt_irq_o, 1'b0);
    rdc(`PIC_PEND_LO_ADR, 32'h0000_0080);
    wr(`PIC_CLAIM_ADR, 32'h0000_0003);
    settle();
    rdc(`PIC_PEND_LO_ADR, 32'h0000_0088);
    rdc(`PIC_PRIO_BASE + 32'd12, 32'h0000_0003);
    wr(`PIC_CLAIM_ADR, 32'h0000_0009);
    rdc(`PIC_EVT_STAT_ADR, 32'h0000_000B);
    wr(`PIC_TCNT_HI_ADR, 32'h0000_0001);
    rdc(`PIC_TCNT_HI_ADR, 32'h0000_0001);
    $display("test external arbitration done");
    give_verdict();
  end
endmodule // platform_interrupt_controller_test
